// ### dv/hru_host_model.sv
// host-side model: follows the ready pulse and counts its fetch points
`timescale 1ns/1ps
module hru_host_model (
    input wire logic mclk,     // 250 MHz clock
    input wire logic srst,     // synchronous reset, high
    input wire logic readyPin, // shared ready pulse pin
    output int fallCnt         // falling edges seen
);
    logic pinDly_r;
    // ==========================================
    // fetch point: the host reads results on each falling edge of the ready pulse
    always_ff @(posedge mclk) begin
        pinDly_r <= readyPin;
        if (srst) begin
            fallCnt <= 0;
        end else if (pinDly_r && !readyPin) begin
            fallCnt <= fallCnt + 1;
        end
    end
endmodule

// ### dv/testbench.sv
// self-checking bench for the harmonic result update control block
`timescale 1ns/1ps
module testbench;
    import hru_pkg::*;
    logic mclk = 0, srst = 1, regWr = 0, regRd = 0, freqOutTwo = 1;
    logic [7:0] regAddr = 0;
    logic [31:0] regWdata = 0, regRdata, d;
    logic [143:0] engRms = 0, engFund = 0;
    logic [167:0] engHd = 0;
    logic [55:0] engThdn = 0;
    logic harmonicIrqN, sharedPin, calcEnable, sampleTick, neutralMode;
    logic [5:0] firstIdx, secondIdx, thirdIdx;
    int fallCnt, errCount = 0, nTests = 0, cyc = 0, k, f0;
    // ==========================================
    // small tick so a sample is 16 clocks and settle waits fit the run
    hru_result_ctrl #(.TICK_CYCLES(16), .RAW_W(28)) u_dut (.mclk(mclk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .engRms(engRms), .engHd(engHd),
        .engThdn(engThdn), .engFund(engFund), .freqOutTwo(freqOutTwo), .harmonicIrqN(harmonicIrqN),
        .sharedPin(sharedPin), .calcEnable(calcEnable), .sampleTick(sampleTick), .neutralMode(neutralMode),
        .firstIdx(firstIdx), .secondIdx(secondIdx), .thirdIdx(thirdIdx));
    hru_host_model u_host (.mclk(mclk), .srst(srst), .readyPin(sharedPin), .fallCnt(fallCnt));
    // clock and hang guard
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 110000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    // ==========================================
    // bus tasks and comparison
    task automatic cy(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regAddr <= a; regWdata <= v; regWr <= 1;
        @(posedge mclk);
        regWr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        regAddr <= a; regRd <= 1;
        @(posedge mclk);
        regRd <= 0;
        #1 d = regRdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
            errCount++;
        end
    endtask
    task automatic waitFall();
        k = 0;
        while (sharedPin !== 1'b0 && k < 20000) begin cy(1); k++; end
    endtask
    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ==========================================
    // test sequence
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 0;
        rd(OFS_HARM_CFG); chk("cfg reset", d, 32'h0000_0008);
        rd(OFS_IDX_FIRST); chk("index reset", d, 32'h0000_0001);
        chk("irq idle", harmonicIrqN, 1);
        freqOutTwo <= 0;
        cy(3); chk("pin freq", sharedPin, 0);
        $display("reset and pin mux done");
        @(posedge mclk);
        engThdn <= {28'h800_0000, 28'h400_0000};
        engHd[27:0] <= 28'h400_0000;
        engFund[23:0] <= 24'h12_3456;
        cy(40);
        rd(OFS_RES_BASE + 12); chk("voltage_distortion_noise_ratio clamp", d, 32'h007F_FFFF);
        rd(OFS_RES_BASE + 13); chk("current_distortion_noise_ratio clamp", d, 32'hFF80_0000);
        rd(OFS_RES_BASE + 6); chk("hd clamp", d, 32'h007F_FFFF);
        rd(OFS_RES_BASE + 14); chk("fund sext", d, 32'h0012_3456);
        $display("formats done");
        wr(OFS_IRQ_MASK_REG_0, 32'h0008_0000);
        wr(OFS_HARM_CFG, 32'h0000_0000);
        cy(62000); rd(OFS_STATUS_REG_0); chk("no flag in settle", d[19], 0);
        cy(4000); rd(OFS_STATUS_REG_0); chk("flag after settle", d[19], 1);
        cy(3); chk("irq low", harmonicIrqN, 0);
        $display("settle done");
        wr(OFS_HARM_CFG, 32'h0000_0081);
        // let the last fast-rate pulse run out before the pin shows it
        cy(2600);
        wr(OFS_CONFIG, 32'h0000_0004);
        wr(OFS_STATUS_REG_0, 32'h0008_0000);
        rd(OFS_STATUS_REG_0); chk("flag cleared", d[19], 0);
        chk("irq released", harmonicIrqN, 1);
        f0 = fallCnt;
        waitFall();
        rd(OFS_STATUS_REG_0); chk("flag no settle", d[19], 1);
        chk("host fetch", fallCnt, f0 + 1);
        k = 0;
        while (sharedPin === 1'b0 && k < 3000) begin cy(1); k++; end
        chk("pulse width", k, 2498);
        waitFall();
        rd(OFS_STATUS_REG_0); chk("flag held", d[19], 1);
        wr(OFS_IRQ_MASK_REG_0, 32'h0000_0000);
        cy(3); chk("irq masked", harmonicIrqN, 1);
        $display("ready pulse done");
        wr(OFS_MODE, 32'h0000_0001);
        @(posedge mclk);
        engThdn <= 0;
        engRms[23:0] <= 24'h00_0111;
        engFund[23:0] <= 24'h65_4321;
        wr(OFS_HARM_CFG, 32'h0000_0001);
        cy(40);
        rd(OFS_RES_BASE); chk("neutral rms", d, 32'h0000_0111);
        rd(OFS_RES_BASE + 6); chk("unity slot", d, 32'h001F_FFFF);
        rd(OFS_RES_BASE + 14); chk("fund held", d, 32'h0012_3456);
        rd(OFS_RES_BASE + 12); chk("thdn held", d, 32'h007F_FFFF);
        $display("neutral done");
        wr(OFS_HARM_CFG, 32'h0000_00E0);
        cy(3); chk("calc off", calcEnable, 0);
        k = 0;
        repeat (100) begin cy(1); k += sampleTick; end
        chk("no ticks", k, 0);
        wr(OFS_HARM_CFG, 32'h0000_0000);
        cy(20); k = 0;
        repeat (160) begin cy(1); k += sampleTick; end
        chk("tick rate", k, 10);
        wr(OFS_IDX_SECOND, 32'h0000_003F);
        rd(OFS_IDX_SECOND); chk("index max", d, 32'h0000_003F);
        rd(8'h09); chk("unmapped", d, 32'h0000_0000);
        $display("rate and index done");
        tallyAndFinish();
    end
endmodule

// ### verilog/hru_pkg.sv
// shared constants for the harmonic result update control block
package hru_pkg;

    // ==========================================
    // register offsets (word index on the plain register port)
    localparam logic [7:0] OFS_HARM_CFG = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h01;
    localparam logic [7:0] OFS_STATUS_REG_0 = 8'h02;
    localparam logic [7:0] OFS_IRQ_MASK_REG_0 = 8'h03;
    localparam logic [7:0] OFS_IDX_FIRST = 8'h04;
    localparam logic [7:0] OFS_IDX_SECOND = 8'h05;
    localparam logic [7:0] OFS_IDX_THIRD = 8'h06;
    localparam logic [7:0] OFS_MODE = 8'h07;
    localparam logic [7:0] OFS_BURST = 8'h08;
    localparam logic [7:0] OFS_RES_BASE = 8'h10;

    // ==========================================
    // field positions and reset values
    localparam int RATE_LSB = 5;
    localparam int SETTLE_LSB = 3;
    localparam int RWS_BIT = 0;
    localparam int PIN_SEL_BIT = 2;
    localparam int FLAG_BIT = 19;
    localparam int NEUTRAL_BIT = 0;
    localparam logic [7:0] HARM_CFG_RST = 8'h08;
    localparam logic [2:0] RATE_OFF = 3'h7;
    localparam logic [5:0] IDX_RST = 6'h01;
    localparam logic [5:0] IDX_FUND = 6'h01;

    // ==========================================
    // result slots: 0-5 slot rms, 6-11 slot distortion, 12-13 thdn, 14-19 fundamental
    localparam int NUM_RES = 20;
    localparam int RES_W = 24;
    localparam int RES_HD_BASE = 6;
    localparam int RES_THDN_BASE = 12;
    localparam int RES_FUND_BASE = 14;
    localparam logic [23:0] RATIO_UNITY = 24'h1F_FFFF;
    localparam logic [23:0] SAT_MAX = 24'h7F_FFFF;
    localparam logic [23:0] SAT_MIN = 24'h80_0000;

    // ==========================================
    // timing
    localparam int CLK_HZ = 250_000_000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAMPLE_HZ = 8000;
    localparam int TICK_CYCLES_DEF = CLK_HZ / SAMPLE_HZ;
    localparam int PULSE_NS = 10000;
    localparam int PULSE_CYCLES = PULSE_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_US = 125;
    localparam int SETTLE_W = 14;

    typedef logic [SETTLE_W-1:0] hru_ticks_t;

    // refresh period in sample ticks for each rate code
    function automatic hru_ticks_t hru_period_ticks(input logic [2:0] sel);
        int us;
        case (sel)
            3'h0: us = 125;
            3'h1: us = 250;
            3'h2: us = 1000;
            3'h3: us = 16000;
            3'h4: us = 128000;
            3'h5: us = 512000;
            default: us = 1024000;
        endcase
        return hru_ticks_t'(us / SAMPLE_US);
    endfunction

    // settle wait in sample ticks for each settle code
    function automatic hru_ticks_t hru_settle_ticks(input logic [1:0] sel);
        int ms;
        case (sel)
            2'h0: ms = 500;
            2'h1: ms = 750;
            2'h2: ms = 1000;
            default: ms = 1250;
        endcase
        return hru_ticks_t'(ms * (SAMPLE_HZ / 1000));
    endfunction

endpackage

// ### verilog/hru_result_ctrl.sv
// harmonic result publishing: refresh timing, ready flag, ready pulse and result registers
//
// Functional notes
// - engine sample tick at 8 kHz, independent of the refresh rate
// - rate field bits 7:5 picks refresh period, 125 us up to 1.024 s
// - rate code 111 switches all harmonic calculation off
// - without ready_without_settle, first flag only after settle wait, then every refresh
// - settle field bits 4:3 picks 500, 750, 1000 or 1250 ms
// - with ready_without_settle, flag at every refresh from the start
// - masked-in flag drives interrupt output low
// - writing one to the flag bit clears it and releases interrupt
// - config bit 2 selects ready pulse or second frequency output on shared pin
// - ready pulse idles high, goes low about 10 us per refresh
// - ready pulse coincides with result register refresh in both modes
// - thdn ratios are 3.21 signed, clamped at +3.9999
// - slot distortions are 3.21 signed, saturated at positive maximum
// - power factor and power results each held in 24-bit signed registers
// - neutral mode refreshes only harmonic rms related results
// - three six-bit index registers, 1 is fundamental, host keeps them at 63 or below
// - neutral mode: current slots hold neutral rms, voltage slots sum rms
// - neutral mode with first index 1: slots b,c relative, slot a reads unity
// - neutral mode: neutral distortion to current slots, sum to voltage slots
// - default settle wait matches typical 750 ms settling after configuration
// - burst port returns all result registers in sequence
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module hru_result_ctrl #(
    parameter int TICK_CYCLES = hru_pkg::TICK_CYCLES_DEF, // clock cycles per 8 kHz sample
    parameter int RAW_W = 28                              // width of engine ratio outputs
) (
    input wire logic mclk,                                      // 250 MHz clock
    input wire logic srst,                                      // synchronous reset, high
    input wire logic [7:0] regAddr,                             // register word index
    input wire logic [31:0] regWdata,                           // write data
    input wire logic regWr,                                     // write strobe
    input wire logic regRd,                                     // read strobe
    output logic [31:0] regRdata,                               // read data, cycle after read
    input wire logic [6*hru_pkg::RES_W-1:0] engRms,             // slot rms a_i,a_v,b_i,b_v,c_i,c_v
    input wire logic [6*RAW_W-1:0] engHd,                       // slot distortion ratios, same order
    input wire logic [2*RAW_W-1:0] engThdn,                     // thdn ratios v (low), i (high)
    input wire logic [6*hru_pkg::RES_W-1:0] engFund,            // fund irms,vrms,pf,watt,var,va
    input wire logic freqOutTwo,                                // second frequency converter output
    output logic harmonicIrqN,                                  // interrupt, active low
    output logic sharedPin,                                     // ready pulse or frequency output
    output logic calcEnable,                                    // engine running
    output logic sampleTick,                                    // 8 kHz engine strobe
    output logic neutralMode,                                   // neutral and sum monitored
    output logic [5:0] firstIdx,                                // first harmonic index
    output logic [5:0] secondIdx,                               // second harmonic index
    output logic [5:0] thirdIdx                                 // third harmonic index
);
    import hru_pkg::*;

    localparam int TICK_W = $clog2(TICK_CYCLES);
    localparam int PULSE_W = $clog2(PULSE_CYCLES + 1);

    initial begin
        if (TICK_CYCLES < 16) begin
            $error("hru_result_ctrl: TICK_CYCLES must be at least 16");
        end
        if (RAW_W < RES_W) begin
            $error("hru_result_ctrl: RAW_W must be at least 24");
        end
    end

    // ==========================================
    // registers
    logic [7:0] harmCfg_r;
    logic pinSel_r;
    logic flag_r;
    logic maskFlag_r;
    logic [5:0] idxFirst_r;
    logic [5:0] idxSecond_r;
    logic [5:0] idxThird_r;
    logic neutral_r;
    logic [TICK_W-1:0] tickCnt_r;
    logic tick_r;
    hru_ticks_t perCnt_r;
    hru_ticks_t settleCnt_r;
    logic [PULSE_W-1:0] pulseCnt_r;
    logic [4:0] burstPtr_r;
    logic [31:0] rdata_r;
    logic irqN_r;
    logic pin_r;
    logic [RES_W-1:0] res_r [NUM_RES];

    logic [2:0] rateSel;
    logic [1:0] settleSel;
    logic rwsBit;
    logic calcOn;
    logic restart;
    logic periodEnd;
    logic publish;
    logic settled;
    logic flagClr;
    logic idxIsFund;
    logic calcNxt;
    hru_ticks_t perTicks;
    hru_ticks_t settleTicks;
    logic [RES_W-1:0] newVal [NUM_RES];
    logic wrEn [NUM_RES];

    assign rateSel = harmCfg_r[RATE_LSB +: 3];
    assign settleSel = harmCfg_r[SETTLE_LSB +: 2];
    assign rwsBit = harmCfg_r[RWS_BIT];
    assign calcOn = (rateSel != RATE_OFF);
    assign perTicks = hru_period_ticks(rateSel);
    assign settleTicks = hru_settle_ticks(settleSel);
    assign idxIsFund = (idxFirst_r == IDX_FUND);
    // enable as it will stand after this edge, so no tick slips out as calc switches off
    assign calcNxt = (regWr && regAddr == OFS_HARM_CFG) ? (regWdata[RATE_LSB +: 3] != RATE_OFF) : calcOn;

    // new configuration or indices restart settling and the refresh period
    assign restart = regWr && (regAddr == OFS_HARM_CFG || regAddr == OFS_IDX_FIRST ||
                               regAddr == OFS_IDX_SECOND || regAddr == OFS_IDX_THIRD);
    assign flagClr = regWr && (regAddr == OFS_STATUS_REG_0) && regWdata[FLAG_BIT];

    // ==========================================
    // software-written configuration
    always_ff @(posedge mclk) begin
        if (srst) begin
            harmCfg_r <= HARM_CFG_RST;
            pinSel_r <= 1'b0;
            maskFlag_r <= 1'b0;
            neutral_r <= 1'b0;
        end else if (regWr) begin
            case (regAddr)
                OFS_HARM_CFG: harmCfg_r <= regWdata[7:0];
                OFS_CONFIG: pinSel_r <= regWdata[PIN_SEL_BIT];
                OFS_IRQ_MASK_REG_0: maskFlag_r <= regWdata[FLAG_BIT];
                OFS_MODE: neutral_r <= regWdata[NEUTRAL_BIT];
                default: ;
            endcase
        end
    end

    // index registers; only six bits exist, so nothing above 63 can be held
    always_ff @(posedge mclk) begin
        if (srst) begin
            idxFirst_r <= IDX_RST;
            idxSecond_r <= IDX_RST;
            idxThird_r <= IDX_RST;
        end else if (regWr) begin
            case (regAddr)
                OFS_IDX_FIRST: idxFirst_r <= regWdata[5:0];
                OFS_IDX_SECOND: idxSecond_r <= regWdata[5:0];
                OFS_IDX_THIRD: idxThird_r <= regWdata[5:0];
                default: ;
            endcase
        end
    end

    // ==========================================
    // fixed 8 kHz engine tick, free of the refresh rate
    always_ff @(posedge mclk) begin
        if (srst) begin
            tickCnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tickCnt_r == TICK_W'(TICK_CYCLES - 1)) begin
            tickCnt_r <= '0;
            tick_r <= calcNxt;
        end else begin
            tickCnt_r <= tickCnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ==========================================
    // refresh period counter, in sample ticks
    assign periodEnd = (perCnt_r == perTicks - 1'b1);
    assign publish = tick_r && calcOn && periodEnd;

    always_ff @(posedge mclk) begin
        if (srst || !calcOn || restart) begin
            perCnt_r <= '0;
        end else if (tick_r) begin
            perCnt_r <= periodEnd ? '0 : perCnt_r + 1'b1;
        end
    end

    // settle wait; default code gives the typical settling time
    assign settled = (settleCnt_r >= settleTicks);

    always_ff @(posedge mclk) begin
        if (srst || !calcOn || restart) begin
            settleCnt_r <= '0;
        end else if (tick_r && !settled) begin
            settleCnt_r <= settleCnt_r + 1'b1;
        end
    end

    // ==========================================
    // ready flag: sticky, a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            flag_r <= 1'b0;
        end else if (publish && (rwsBit || settled)) begin
            flag_r <= 1'b1;
        end else if (flagClr) begin
            flag_r <= 1'b0;
        end
    end

    // interrupt follows the flag one cycle later
    always_ff @(posedge mclk) begin
        if (srst) begin
            irqN_r <= 1'b1;
        end else begin
            irqN_r <= !(flag_r && maskFlag_r);
        end
    end

    // ==========================================
    // ready pulse, launched by the same strobe that loads the results
    always_ff @(posedge mclk) begin
        if (srst) begin
            pulseCnt_r <= '0;
        end else if (publish) begin
            pulseCnt_r <= PULSE_W'(PULSE_CYCLES);
        end else if (pulseCnt_r != '0) begin
            pulseCnt_r <= pulseCnt_r - 1'b1;
        end
    end

    // pin mux; the converter output is same-clock logic, so no synchroniser
    always_ff @(posedge mclk) begin
        if (srst) begin
            pin_r <= 1'b1;
        end else if (pinSel_r) begin
            pin_r <= (pulseCnt_r == '0);
        end else begin
            pin_r <= freqOutTwo;
        end
    end

    // ==========================================
    // next result values and their write enables per slot
    genvar gi;
    generate
        for (gi = 0; gi < NUM_RES; gi++) begin : g_slot
            if (gi < RES_HD_BASE) begin : g_rms
                // neutral mode: current slots neutral, voltage slots the phase sum
                assign newVal[gi] = engRms[gi*RES_W +: RES_W];
                assign wrEn[gi] = 1'b1;
            end else if (gi < RES_THDN_BASE) begin : g_hd
                logic [RES_W-1:0] sat;
                hru_sat_clamp #(.IN_W(RAW_W)) u_clamp (
                    .rawIn(engHd[(gi-RES_HD_BASE)*RAW_W +: RAW_W]),
                    .satOut(sat)
                );
                if (gi < RES_HD_BASE + 2) begin : g_first
                    // fundamental against itself reads 1F_FFFF, one LSB short of one in 3.21
                    assign newVal[gi] = (neutral_r && idxIsFund) ? RATIO_UNITY : sat;
                end else begin : g_other
                    assign newVal[gi] = sat;
                end
                // without index 1 there is no fundamental to divide by
                assign wrEn[gi] = !neutral_r || idxIsFund;
            end else if (gi < RES_FUND_BASE) begin : g_thdn
                hru_sat_clamp #(.IN_W(RAW_W)) u_clamp (
                    .rawIn(engThdn[(gi-RES_THDN_BASE)*RAW_W +: RAW_W]),
                    .satOut(newVal[gi])
                );
                assign wrEn[gi] = !neutral_r;
            end else begin : g_fund
                assign newVal[gi] = engFund[(gi-RES_FUND_BASE)*RES_W +: RES_W];
                assign wrEn[gi] = !neutral_r;
            end

            // result register load on each refresh
            always_ff @(posedge mclk) begin
                if (srst) begin
                    res_r[gi] <= '0;
                end else if (publish && wrEn[gi]) begin
                    res_r[gi] <= newVal[gi];
                end
            end
        end
    endgenerate

    // ==========================================
    // burst pointer: rewinds at each refresh, so a read train after the
    // pulse edge gets one coherent result set
    always_ff @(posedge mclk) begin
        if (srst || publish || (regWr && regAddr == OFS_BURST)) begin
            burstPtr_r <= '0;
        end else if (regRd && regAddr == OFS_BURST) begin
            burstPtr_r <= (burstPtr_r == 5'(NUM_RES - 1)) ? '0 : burstPtr_r + 1'b1;
        end
    end

    // register read; data stand one cycle only, unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (srst || !regRd) begin
            rdata_r <= '0;
        end else if (regAddr >= OFS_RES_BASE && regAddr < OFS_RES_BASE + 8'(NUM_RES)) begin
            rdata_r <= {{8{res_r[5'(regAddr - OFS_RES_BASE)][RES_W-1]}}, res_r[5'(regAddr - OFS_RES_BASE)]};
        end else begin
            case (regAddr)
                OFS_HARM_CFG: rdata_r <= {24'h00_0000, harmCfg_r};
                OFS_CONFIG: rdata_r <= 32'(pinSel_r) << PIN_SEL_BIT;
                OFS_STATUS_REG_0: rdata_r <= 32'(flag_r) << FLAG_BIT;
                OFS_IRQ_MASK_REG_0: rdata_r <= 32'(maskFlag_r) << FLAG_BIT;
                OFS_IDX_FIRST: rdata_r <= {26'h000_0000, idxFirst_r};
                OFS_IDX_SECOND: rdata_r <= {26'h000_0000, idxSecond_r};
                OFS_IDX_THIRD: rdata_r <= {26'h000_0000, idxThird_r};
                OFS_MODE: rdata_r <= {31'h0000_0000, neutral_r};
                OFS_BURST: rdata_r <= {{8{res_r[burstPtr_r][RES_W-1]}}, res_r[burstPtr_r]};
                default: rdata_r <= '0;
            endcase
        end
    end

    // ==========================================
    // outputs, all from flops except calcEnable, which is decoded from the rate field
    assign regRdata = rdata_r;
    assign harmonicIrqN = irqN_r;
    assign sharedPin = pin_r;
    assign calcEnable = calcOn;
    assign sampleTick = tick_r;
    assign neutralMode = neutral_r;
    assign firstIdx = idxFirst_r;
    assign secondIdx = idxSecond_r;
    assign thirdIdx = idxThird_r;

    // ==========================================
    // checks
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (srst)
        flag_r && !flagClr |=> flag_r)
        else $error("ready flag dropped without a clear");

    chk_flag_clear: assert property (@(posedge mclk) disable iff (srst)
        flagClr && !publish |=> !flag_r ##1 harmonicIrqN)
        else $error("flag clear did not clear flag and release interrupt");

    chk_set_wins: assert property (@(posedge mclk) disable iff (srst)
        publish && rwsBit |=> flag_r)
        else $error("refresh did not set flag in no-settle mode");

    chk_no_early_flag: assert property (@(posedge mclk) disable iff (srst)
        publish && !rwsBit && !settled && !flag_r |=> !flag_r)
        else $error("flag set before settle wait elapsed");

    chk_irq_level: assert property (@(posedge mclk) disable iff (srst)
        flag_r && maskFlag_r |=> !harmonicIrqN)
        else $error("masked-in flag did not pull interrupt low");

    chk_pulse_width: assert property (@(posedge mclk) disable iff (srst)
        publish && pinSel_r && !regWr |=> ##1 (!sharedPin)[*8])
        else $error("ready pulse not held low");

    chk_calc_off: assert property (@(posedge mclk) disable iff (srst)
        !calcOn |-> !publish && !sampleTick ##1 !publish)
        else $error("refresh while calculations disabled");

    chk_period_gap: assert property (@(posedge mclk) disable iff (srst)
        publish |=> !publish[*8])
        else $error("refreshes closer than one sample period");

    chk_unity_slot: assert property (@(posedge mclk) disable iff (srst)
        publish && neutral_r && idxIsFund |=> res_r[RES_HD_BASE] == RATIO_UNITY)
        else $error("first slot distortion not unity in neutral mode");

    chk_fund_hold: assert property (@(posedge mclk) disable iff (srst)
        publish && neutral_r |=> $stable(res_r[RES_FUND_BASE]) && $stable(res_r[RES_THDN_BASE]))
        else $error("non-rms result changed in neutral mode");

endmodule

// ### verilog/hru_sat_clamp.sv
// saturating clamp of a wide signed ratio into 24-bit 3.21 format
`timescale 1ns/1ps
module hru_sat_clamp #(
    parameter int IN_W = 28
) (
    input wire logic signed [IN_W-1:0] rawIn, // engine ratio, x.21 signed
    output logic [hru_pkg::RES_W-1:0] satOut  // clamped 3.21 value
);
    import hru_pkg::*;

    initial begin
        if (IN_W < RES_W) begin
            $error("hru_sat_clamp: IN_W must be at least 24");
        end
    end

    localparam logic signed [IN_W-1:0] MAX_W = IN_W'(signed'(SAT_MAX));
    localparam logic signed [IN_W-1:0] MIN_W = IN_W'(signed'(SAT_MIN));

    // ==========================================
    // clamp; negative side saturates too so the sign never flips
    always_comb begin
        if (rawIn > MAX_W) begin
            satOut = SAT_MAX;
        end else if (rawIn < MIN_W) begin
            satOut = SAT_MIN;
        end else begin
            satOut = rawIn[RES_W-1:0];
        end
    end

endmodule
